// *** core/sar_pkg.sv ***
package sar_pkg;

  localparam int unsigned RES_BITS = 18;
  localparam int unsigned CLK_MHZ  = 250;

  // Mode encoding on mode_sel
  localparam logic [1:0] MODE_NORMAL  = 2'h0;
  localparam logic [1:0] MODE_FAST    = 2'h1;
  localparam logic [1:0] MODE_LOWPWR  = 2'h2;

  // Throughput figures in kSPS
  localparam int unsigned RATE_FAST_KSPS   = 800;
  localparam int unsigned RATE_NORMAL_KSPS = 666;
  localparam int unsigned RATE_LOWPWR_KSPS = 570;

  // Cycles per sample period, rounded down (longest allowed period for the rate)
  localparam int unsigned PER_FAST_CYC   = (CLK_MHZ * 1000) / RATE_FAST_KSPS;
  localparam int unsigned PER_NORMAL_CYC = (CLK_MHZ * 1000) / RATE_NORMAL_KSPS;
  localparam int unsigned PER_LOWPWR_CYC = (CLK_MHZ * 1000) / RATE_LOWPWR_KSPS;

  // Cycles for one approximation step
  localparam int unsigned STEP_CYC = 4;
  localparam int unsigned CONV_CYC = RES_BITS * STEP_CYC + 2;

  // Acquisition cycles in each mode: period minus conversion
  localparam logic [9:0] ACQ_FAST_CYC   = 10'(PER_FAST_CYC - CONV_CYC);
  localparam logic [9:0] ACQ_NORMAL_CYC = 10'(PER_NORMAL_CYC - CONV_CYC);
  localparam logic [9:0] ACQ_LOWPWR_CYC = 10'(PER_LOWPWR_CYC - CONV_CYC);

  localparam logic [RES_BITS-1:0] CODE_MIN = 18'h00000;
  localparam logic [RES_BITS-1:0] CODE_MAX = 18'h3ffff;
  localparam logic [RES_BITS-1:0] CODE_MID = 18'h20000;
  localparam logic [RES_BITS-1:0] CODE_RST = 18'h00000;
  localparam logic [1:0]          STEP_LAST = 2'(STEP_CYC - 1);

endpackage : sar_pkg

// *** core/sar_bit_trial.sv ***
`timescale 1ns/1ps
// One successive-approximation trial: keep or drop the trial bit
module sar_bit_trial
  import sar_pkg::*;
(
  input  wire logic [RES_BITS-1:0] code_in,
  input  wire logic [RES_BITS-1:0] bit_mask,
  input  wire logic                keep,
  output logic      [RES_BITS-1:0] code_out
);
  always_comb begin
    code_out = code_in | bit_mask;
    if (!keep) begin
      code_out = code_in;
    end
  end
endmodule : sar_bit_trial

// *** core/sar_conversion_sequencer.sv ***
`timescale 1ns/1ps
// Functional notes
// [R1] Eighteen binary-weighted trials, MSB first down to LSB weight 1/262144.
// [R2] After the last trial, form the output code and drop busy.
// [R3] Conversion starts only after acquisition ends and convert-start falls; in low-power mode a held-low level also starts it.
// [R4] Result readable right after its own conversion, no pipeline latency.
// [R5] Fast mode sustains up to 800 kSPS.
// [R6] Host discards fast-mode result after gaps above 1 ms.
// [R7] Normal mode up to 666 kSPS, no limit on gap.
// [R8] Low-power mode saves power between conversions, up to 570 kSPS.
// [R9] Coding select works in all modes except full 18-bit parallel.
// [R10] Binary midscale 20000, ends 3FFFF/00000; two's complement 00000,1FFFF,20000.
// [R11] Over-range input saturates to maximum code of the selected coding.
// [R12] Under-range input saturates to minimum code of the selected coding.
// [R13] Busy high from conversion start until result latched.
// [R14] A started conversion is never aborted or restarted, even by power-down.
// [R15] Low-power mode: convert-start held low while idle auto-starts after acquisition.
// [R16] Two's complement derived by inverting the binary MSB.
module sar_conversion_sequencer
  import sar_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                convert_start_n,
  input  wire logic                coding_select,
  input  wire logic                power_down_in,
  input  wire logic [1:0]          mode_sel,
  input  wire logic                parallel_18bit,
  input  wire logic                comp_high,
  input  wire logic                over_range,
  input  wire logic                under_range,
  output logic                     busy,
  output logic                     acq_done,
  output logic                     low_power,
  output logic     [RES_BITS-1:0]  trial_code,
  output logic     [RES_BITS-1:0]  result
);

  typedef enum logic [1:0] {ST_ACQ, ST_IDLE, ST_CONV, ST_DONE} state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  // Only the second flop of each pair feeds logic
  logic [1:0] cnv_sync_q;
  logic [1:0] pd_sync_q;
  logic [1:0] cs_sync_q;
  logic [1:0] cmp_sync_q;
  logic       cnv_prev_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnv_sync_q <= 2'h3;
      pd_sync_q  <= 2'h0;
      cs_sync_q  <= 2'h0;
      cmp_sync_q <= 2'h0;
      cnv_prev_q <= 1'b1;
    end else begin
      cnv_sync_q <= {cnv_sync_q[0], convert_start_n};
      pd_sync_q  <= {pd_sync_q[0], power_down_in};
      cs_sync_q  <= {cs_sync_q[0], coding_select};
      cmp_sync_q <= {cmp_sync_q[0], comp_high};
      cnv_prev_q <= cnv_sync_q[1];
    end
  end

  logic cnv_low;
  logic cnv_fall;
  assign cnv_low  = !cnv_sync_q[1];
  assign cnv_fall = cnv_prev_q && !cnv_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing
  state_e                state_q;
  logic [9:0]            acq_cnt_q;
  logic [4:0]            bit_idx_q;
  logic [1:0]            step_cnt_q;
  logic [RES_BITS-1:0]   code_q;
  logic [RES_BITS-1:0]   result_q;
  logic                  over_q;
  logic                  under_q;
  logic [9:0]            acq_len;
  logic [RES_BITS-1:0]   bit_mask;
  logic [RES_BITS-1:0]   code_next;
  logic                  start_ok;
  logic                  take;
  logic                  step_end;
  logic                  last_bit;
  logic                  acq_end;

  always_comb begin
    unique case (mode_sel)
      MODE_FAST:   acq_len = ACQ_FAST_CYC;   // [R5]
      MODE_LOWPWR: acq_len = ACQ_LOWPWR_CYC; // [R8]
      default:     acq_len = ACQ_NORMAL_CYC; // [R7]
    endcase
  end

  assign bit_mask = CODE_MID >> bit_idx_q; // [R1]

  sar_bit_trial u_trial (
    .code_in  (code_q),
    .bit_mask (bit_mask),
    .keep     (!cmp_sync_q[1]),
    .code_out (code_next)
  );

  // Fall starts from idle; in low-power mode a held-low level also starts
  assign start_ok = !pd_sync_q[1] &&
                    (cnv_fall || (mode_sel == MODE_LOWPWR && cnv_low)); // [R3] [R15]

  assign take     = (state_q == ST_IDLE) && start_ok; // [R3]
  assign step_end = (state_q == ST_CONV) && (step_cnt_q == STEP_LAST);
  assign last_bit = (bit_idx_q == 5'(RES_BITS - 1));
  // Acquisition takes acq_len cycles, so take-to-take fits the mode rate
  assign acq_end  = (acq_cnt_q >= acq_len - 10'h001); // [R5] [R7] [R8]

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_ACQ;
    end else begin
      unique case (state_q)
        ST_ACQ: begin
          if (acq_end) begin
            state_q <= ST_IDLE; // [R3]
          end
        end
        ST_IDLE: begin
          if (start_ok) begin
            state_q <= ST_CONV; // [R3]
          end
        end
        ST_CONV: begin
          // No abort path: power-down and convert-start are ignored here
          if (step_end && last_bit) begin
            state_q <= ST_DONE; // [R2] [R14]
          end
        end
        ST_DONE: begin
          state_q <= ST_ACQ;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acq_cnt_q <= 10'h000;
    end else if (state_q == ST_DONE) begin
      acq_cnt_q <= 10'h000;
    end else if (state_q == ST_ACQ) begin
      acq_cnt_q <= acq_cnt_q + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      step_cnt_q <= 2'h0;
      bit_idx_q  <= 5'h00;
    end else if (take) begin
      step_cnt_q <= 2'h0;
      bit_idx_q  <= 5'h00;
    end else if (state_q == ST_CONV) begin
      step_cnt_q <= step_cnt_q + 2'h1; // [R14]
      if (step_end && !last_bit) begin
        bit_idx_q <= bit_idx_q + 5'h01; // [R1]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      code_q <= CODE_RST;
    end else if (take) begin
      code_q <= CODE_RST;
    end else if (step_end) begin
      code_q <= code_next; // [R1]
    end
  end

  // Range flags captured with the sample, held for the whole conversion
  always_ff @(posedge clk) begin
    if (rst) begin
      over_q  <= 1'b0;
      under_q <= 1'b0;
    end else if (take) begin
      over_q  <= over_range;
      under_q <= under_range;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output code formation
  logic [RES_BITS-1:0] bin_code;
  always_comb begin
    bin_code = code_q;
    if (over_q) begin
      bin_code = CODE_MAX; // [R11]
    end else if (under_q) begin
      bin_code = CODE_MIN; // [R12]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      result_q <= CODE_RST;
    end else if (state_q == ST_DONE) begin
      // Twos complement only when not in full-width parallel mode
      if (!cs_sync_q[1] && !parallel_18bit) begin
        result_q <= bin_code ^ CODE_MID; // [R9] [R10] [R16]
      end else begin
        result_q <= bin_code; // [R10] [R4]
      end
    end
  end

  assign busy       = (state_q == ST_CONV) || (state_q == ST_DONE); // [R13]
  assign acq_done   = (state_q == ST_IDLE);
  assign low_power  = (mode_sel == MODE_LOWPWR) && !busy; // [R8]
  assign trial_code = code_q | bit_mask;
  assign result     = result_q;

endmodule : sar_conversion_sequencer

// *** tb/comp_model.sv ***
`timescale 1ns/1ps
module comp_model
  import sar_pkg::*;
(
  input  wire logic [RES_BITS-1:0] sample,
  input  wire logic [RES_BITS-1:0] trial_code,
  output logic                     comp_high
);
  // Trial above held sample drops the bit
  assign comp_high = trial_code > sample;
endmodule : comp_model

// *** tb/sar_seq_props.sv ***
`timescale 1ns/1ps
module sar_seq_props
  import sar_pkg::*;
(
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                coding_select,
  input wire logic                parallel_18bit,
  input wire logic                over_range,
  input wire logic                under_range,
  input wire logic                busy,
  input wire logic                acq_done,
  input wire logic [RES_BITS-1:0] trial_code,
  input wire logic [RES_BITS-1:0] result
);
  logic [7:0] cnt_q;
  logic       bin;
  always_ff @(posedge clk) cnt_q <= busy ? cnt_q + 8'h01 : 8'h00;
  assign bin = coding_select | parallel_18bit;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  busy_len_a: assert property ($fell(busy) |-> cnt_q == 8'h49) else $error("busy length");
  result_hold_a: assert property ($changed(result) |-> $fell(busy)) else $error("result moved");
  acq_excl_a: assert property (busy |-> !acq_done) else $error("acq_done in busy");
  start_gate_a: assert property ($rose(busy) |-> $past(acq_done)) else $error("early start");
  msb_first_a: assert property ($rose(busy) |-> trial_code == CODE_MID) else $error("first trial");
  bit_order_a: assert property ($rose(busy) |-> ##4 trial_code[16]) else $error("second trial");
  over_sat_a: assert property ($fell(busy) && over_range |->
    result == (bin ? CODE_MAX : CODE_MAX ^ CODE_MID)) else $error("over sat");
  under_sat_a: assert property ($fell(busy) && under_range && !over_range |->
    result == (bin ? CODE_MIN : CODE_MID)) else $error("under sat");
endmodule : sar_seq_props
bind sar_conversion_sequencer sar_seq_props chk_u (.clk(clk), .rst(rst), .coding_select(coding_select),
  .parallel_18bit(parallel_18bit), .over_range(over_range), .under_range(under_range), .busy(busy),
  .acq_done(acq_done), .trial_code(trial_code), .result(result));

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench
  import sar_pkg::*;
;
  logic                clk = 0, rst = 1, cvs_n = 1, cs = 1, par = 0, ov = 0, un = 0, pd = 0;
  logic                comp_high, busy, acq_done, low_power;
  logic [1:0]          mode_sel = MODE_NORMAL;
  logic [RES_BITS-1:0] sample = '0, trial_code, result;
  int                  err_count = 0, total_checks = 0;
  always #2 clk = ~clk;
  sar_conversion_sequencer dut_u (.clk(clk), .rst(rst), .convert_start_n(cvs_n), .coding_select(cs),
    .power_down_in(pd), .mode_sel(mode_sel), .parallel_18bit(par), .comp_high(comp_high), .over_range(ov),
    .under_range(un), .busy(busy), .acq_done(acq_done), .low_power(low_power), .trial_code(trial_code),
    .result(result));
  comp_model cmp_u (.sample(sample), .trial_code(trial_code), .comp_high(comp_high));
  task automatic chk(input string n, input logic [RES_BITS-1:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic wt(input bit a, input logic v);
    for (int i = 0; i < 2000 && (a ? acq_done : busy) !== v; i++) @(posedge clk);
    if ((a ? acq_done : busy) !== v) begin
      err_count++;
      wrap_up();
    end
  endtask : wt
  // Start once idle, hold until taken
  task automatic conv(input logic [RES_BITS-1:0] s, input logic c, o, u, input logic [RES_BITS-1:0] e);
    int n;
    int per;
    wt(1, 1);
    @(posedge clk);
    per = (mode_sel == MODE_FAST) ? PER_FAST_CYC : (mode_sel == MODE_LOWPWR) ? PER_LOWPWR_CYC : PER_NORMAL_CYC;
    sample <= s;
    cs <= c;
    ov <= o;
    un <= u;
    cvs_n <= 0;
    wt(0, 1);
    @(posedge clk) cvs_n <= 1;
    wt(0, 0);
    chk("result", result, e);
    n = 0;
    while (acq_done !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk("period", {17'h0, n + CONV_CYC <= per}, 18'h1);
    $display("conversion test done");
  endtask : conv
  task automatic busy_refuse;
    conv(18'h00001, 1, 0, 0, 18'h00001);
    @(posedge clk);
    sample <= 18'h15555;
    cvs_n  <= 0;
    wt(0, 1);
    @(posedge clk);
    cvs_n <= 1;
    pd    <= 1;
    repeat (8) @(posedge clk);
    cvs_n <= 0;
    repeat (8) @(posedge clk);
    cvs_n <= 1;
    wt(0, 0);
    chk("pd_keep", result, 18'h15555);
    pd    <= 0;
    cvs_n <= 0;
    repeat (8) @(posedge clk);
    cvs_n <= 1;
    wt(1, 1);
    repeat (8) @(posedge clk);
    chk("acq_refuse", {17'h0, busy}, 18'h0);
    $display("refuse test done");
  endtask : busy_refuse
  task automatic auto_run;
    int n;
    mode_sel <= MODE_LOWPWR;
    wt(1, 1);
    @(posedge clk) cvs_n <= 0;
    wt(0, 1);
    wt(0, 0);
    chk("low_power", {17'h0, low_power}, 18'h1);
    n = 0;
    while (busy !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    // Busy is seen one edge after the automatic take
    chk("auto_start", {17'h0, n + CONV_CYC <= PER_LOWPWR_CYC + 1}, 18'h1);
    @(posedge clk) cvs_n <= 1;
    wt(0, 0);
    mode_sel <= MODE_NORMAL;
    $display("auto test done");
  endtask : auto_run
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    chk("rst_busy", {17'h0, busy}, 18'h0);
    chk("rst_acq", {17'h0, acq_done}, 18'h0);
    chk("rst_result", result, CODE_RST);
    conv(18'h20000, 1, 0, 0, 18'h20000);
    conv(18'h20000, 0, 0, 0, 18'h00000);
    conv(18'h3ffff, 0, 0, 0, 18'h1ffff);
    conv(18'h00000, 0, 0, 0, 18'h20000);
    conv(18'h2a5c3, 1, 0, 0, 18'h2a5c3);
    conv(18'h00005, 0, 1, 0, 18'h1ffff);
    conv(18'h3fff0, 1, 0, 1, 18'h00000);
    par <= 1;
    conv(18'h20000, 0, 1, 0, 18'h3ffff);
    par <= 0;
    // Back-to-back runs keep fast-mode gaps short
    for (int m = 0; m < 4; m++) begin
      mode_sel <= 2'(m);
      conv(18'h0abcd, 1, 0, 0, 18'h0abcd);
    end
    busy_refuse();
    auto_run();
    wrap_up();
  end
endmodule : testbench
